// ==== common/tds_pkg.sv ====
// constants, types and register map of the transfer delay sequencer
package tds_pkg;
  // clock and one-second tick
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned TICK_S      = 1;
  localparam int unsigned TICK_CYCLES = TICK_S * CLK_HZ;
  // delays in seconds or minutes
  localparam logic [11:0] DWELL_LONG_S = 12'h005;
  localparam logic [11:0] DWELL_ZERO_S = 12'h000;
  localparam logic [11:0] SHED_WAIT_S  = 12'h000;
  localparam logic [5:0]  COOL_S       = 6'h3C;
  localparam logic [11:0] MIN_TO_S     = 12'h03C;
  // register byte addresses
  localparam logic [3:0] ADR_CTRL   = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [3:0] ADR_TIMER  = 4'h8;
  // control register layout, low 16 bits of the word
  typedef struct packed {
    logic [3:0] gst_sel;
    logic [3:0] retx_sel;
    logic [1:0] rsvd;
    logic       shed_en;
    logic       gen_mod;
    logic       ext_pwr;
    logic       ug_mode;
    logic       auto_ret;
    logic       dwell5;
  } tds_cfg_s;
  localparam logic [15:0] CTRL_RST = 16'h310E;
  // status and timer register field positions
  localparam int unsigned ST_N_OK  = 3;
  localparam int unsigned ST_A_OK  = 4;
  localparam int unsigned ST_POS_N = 5;
  localparam int unsigned ST_POS_A = 6;
  localparam int unsigned ST_GSTRT = 7;
  localparam int unsigned ST_GSTOP = 8;
  localparam int unsigned ST_SHED  = 9;
  localparam int unsigned ST_COOL  = 10;
  localparam int unsigned TM_COOL  = 16;
  // sequencer states
  typedef enum logic [2:0] {
    S_ON_N   = 3'b000,
    S_GSTART = 3'b001,
    S_WAIT_A = 3'b010,
    S_DWELLA = 3'b011,
    S_ON_A   = 3'b100,
    S_RETX   = 3'b101,
    S_DWELLN = 3'b110
  } tds_state_e;
endpackage

// ==== core/tds_core.sv ====
// transfer delay sequencer: switch timing, generator start/stop, load shed
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - hold center-off for 0 or 5 s dwell
// - same dwell toward normal and alternate
// - auto-return waits re-transfer timer, watching sources
// - normal fails during timer: cancel return
// - alternate fails, normal good: return immediately
// - generator start waits selectable start delay
// - start delay only with external power/module
// - load-shed wait fixed zero seconds, both modes
// - drive load-shed output while on alternate
// - 60 s cool-down before generator stop
// - cool-down also runs after restart, U-G
// - cool-down gated by start-delay end or alternate
// - return to normal in auto-return mode, or when alternate fails
// - cool-down follows re-transfer to normal
module tds_core #(
  parameter int unsigned TICK_CYC = tds_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // source sensors, asynchronous
  input  wire logic        n_ok_i,
  input  wire logic        a_ok_i,
  // actuator and contacts
  output logic             pos_n_o,
  output logic             pos_a_o,
  output logic             gen_start_o,
  output logic             gen_stop_o,
  output logic             load_shed_o
);
  // selector index to step value 0,1,2,3,5,10,20,30,60
  function automatic logic [11:0] step_val(input logic [3:0] idx);
    case (idx)
      4'h0: step_val = 12'h000;
      4'h1: step_val = 12'h001;
      4'h2: step_val = 12'h002;
      4'h3: step_val = 12'h003;
      4'h4: step_val = 12'h005;
      4'h5: step_val = 12'h00A;
      4'h6: step_val = 12'h014;
      4'h7: step_val = 12'h01E;
      default: step_val = 12'h03C;
    endcase
  endfunction

  // sensor synchronisers
  logic n_m_q, n_ok;
  logic a_m_q, a_ok;
  always_ff @(posedge clk_i) begin
    n_m_q <= n_ok_i;
    n_ok  <= n_m_q;
    a_m_q <= a_ok_i;
    a_ok  <= a_m_q;
  end

  // one-second tick; long period kept a parameter for simulation
  logic [31:0] div_q, div_d;
  logic        tick;
  logic        restart;
  always_comb begin
    tick  = (div_q == TICK_CYC - 1);
    // a state change restarts the second, so no delay is cut short by a part tick
    div_d = (tick || restart) ? 32'h0 : div_q + 32'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) div_q <= 32'h0;
    else div_q <= div_d;
  end

  // wishbone registers
  tds_pkg::tds_cfg_s cfg_q, cfg_d;
  logic              ack_q, ack_d;
  logic [31:0]       rd_d, rd_q;
  logic [15:0]       wr;
  logic [31:0]       status, timer;
  logic              acc;
  always_comb begin
    acc = cyc_i && stb_i && !ack_q;
    wr  = cfg_q;
    if (sel_i[0]) wr[7:0] = dat_i[7:0];
    if (sel_i[1]) wr[15:8] = dat_i[15:8];
    wr[7:6] = 2'h0;
    cfg_d = cfg_q;
    rd_d  = 32'h0;
    ack_d = acc;
    if (adr_i == tds_pkg::ADR_CTRL) begin
      rd_d = {16'h0, cfg_q};
      // writes land on the edge at which the master sees ack
      if (cyc_i && stb_i && we_i && ack_q) cfg_d = wr;
    end else if (adr_i == tds_pkg::ADR_STATUS) begin
      rd_d = status;
    end else if (adr_i == tds_pkg::ADR_TIMER) begin
      rd_d = timer;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= tds_pkg::CTRL_RST;
      ack_q <= 1'b0;
      rd_q  <= 32'h0;
    end else begin
      cfg_q <= cfg_d;
      ack_q <= ack_d;
      rd_q  <= rd_d;
    end
  end
  assign ack_o = ack_q;
  assign dat_o = rd_q;

  // sequencer
  tds_pkg::tds_state_e st_q, st_d;
  logic [11:0] sec_q, sec_d;
  logic        gdone_q, gdone_d;
  logic        gst_q, gst_d;
  logic        gstop_q, gstop_d;
  logic        shed_q, shed_d;
  logic        crun_q, crun_d;
  logic [5:0]  cool_q, cool_d;
  logic [11:0] dwell_s, gst_s, retx_s;
  logic        expired;
  always_comb begin
    dwell_s = cfg_q.dwell5 ? tds_pkg::DWELL_LONG_S : tds_pkg::DWELL_ZERO_S;
    gst_s   = (cfg_q.ext_pwr || cfg_q.gen_mod) ? step_val(cfg_q.gst_sel) : 12'h000;
    retx_s  = 12'(step_val(cfg_q.retx_sel) * tds_pkg::MIN_TO_S);
    expired = (sec_q == 12'h000);
    st_d    = st_q;
    sec_d   = (tick && !expired) ? sec_q - 12'h001 : sec_q;
    gdone_d = gdone_q;
    gst_d   = gst_q;
    gstop_d = gstop_q;
    crun_d  = crun_q;
    cool_d  = cool_q;
    case (st_q)
      tds_pkg::S_ON_N: begin
        if (!n_ok) begin
          if (cfg_q.ug_mode) begin
            st_d    = tds_pkg::S_GSTART;
            sec_d   = gst_s;
            gdone_d = 1'b0;
            crun_d  = 1'b0;
          end else if (a_ok) begin
            st_d  = tds_pkg::S_DWELLA;
            sec_d = dwell_s;
          end
        end
      end
      tds_pkg::S_GSTART: begin
        if (n_ok) begin
          st_d = tds_pkg::S_ON_N;
        end else if (expired) begin
          st_d    = tds_pkg::S_WAIT_A;
          gst_d   = 1'b1;
          gstop_d = 1'b0;
          gdone_d = 1'b1;
        end
      end
      tds_pkg::S_WAIT_A: begin
        if (a_ok) begin
          st_d  = tds_pkg::S_DWELLA;
          sec_d = dwell_s;
        end else if (n_ok) begin
          st_d   = tds_pkg::S_ON_N;
          crun_d = cfg_q.ug_mode;
          cool_d = tds_pkg::COOL_S;
        end
      end
      tds_pkg::S_DWELLA: begin
        if (expired) st_d = tds_pkg::S_ON_A;
      end
      tds_pkg::S_ON_A: begin
        if (n_ok && cfg_q.auto_ret) begin
          st_d  = tds_pkg::S_RETX;
          sec_d = retx_s;
        end else if (n_ok && !a_ok) begin
          st_d  = tds_pkg::S_DWELLN;
          sec_d = dwell_s;
        end
      end
      tds_pkg::S_RETX: begin
        if (!n_ok) begin
          st_d = tds_pkg::S_ON_A;
        end else if (!a_ok || expired) begin
          st_d  = tds_pkg::S_DWELLN;
          sec_d = dwell_s;
        end
      end
      tds_pkg::S_DWELLN: begin
        if (expired) begin
          st_d   = tds_pkg::S_ON_N;
          crun_d = cfg_q.ug_mode && gst_q;
          cool_d = tds_pkg::COOL_S;
        end
      end
      default: st_d = tds_pkg::S_ON_N;
    endcase
    if (crun_q && st_d == tds_pkg::S_ON_N) begin
      if (!cfg_q.ug_mode) begin
        crun_d = 1'b0;
      end else if (tick && (gdone_q || a_ok)) begin
        if (cool_q == 6'h01 || cool_q == 6'h00) begin
          crun_d  = 1'b0;
          gst_d   = 1'b0;
          gstop_d = 1'b1;
        end
        cool_d = cool_q - 6'h01;
      end
    end
    // shed wait is zero seconds, so shedding follows the alternate at once
    shed_d = cfg_q.shed_en && (st_d == tds_pkg::S_ON_A || st_d == tds_pkg::S_RETX)
             && (tds_pkg::SHED_WAIT_S == 12'h000);
    restart = (st_d != st_q);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q    <= tds_pkg::S_ON_N;
      sec_q   <= 12'h000;
      gdone_q <= 1'b0;
      gst_q   <= 1'b0;
      gstop_q <= 1'b0;
      shed_q  <= 1'b0;
      crun_q  <= tds_pkg::CTRL_RST[2];
      cool_q  <= tds_pkg::COOL_S;
    end else begin
      st_q    <= st_d;
      sec_q   <= sec_d;
      gdone_q <= gdone_d;
      gst_q   <= gst_d;
      gstop_q <= gstop_d;
      shed_q  <= shed_d;
      crun_q  <= crun_d;
      cool_q  <= cool_d;
    end
  end

  // actuator: both closed outputs low is the center-off position
  assign pos_n_o     = (st_q == tds_pkg::S_ON_N) || (st_q == tds_pkg::S_GSTART)
                       || (st_q == tds_pkg::S_WAIT_A);
  assign pos_a_o     = (st_q == tds_pkg::S_ON_A) || (st_q == tds_pkg::S_RETX);
  assign gen_start_o = gst_q;
  assign gen_stop_o  = gstop_q;
  assign load_shed_o = shed_q;

  always_comb begin
    status = 32'h0;
    status[2:0] = st_q;
    status[tds_pkg::ST_N_OK]  = n_ok;
    status[tds_pkg::ST_A_OK]  = a_ok;
    status[tds_pkg::ST_POS_N] = pos_n_o;
    status[tds_pkg::ST_POS_A] = pos_a_o;
    status[tds_pkg::ST_GSTRT] = gst_q;
    status[tds_pkg::ST_GSTOP] = gstop_q;
    status[tds_pkg::ST_SHED]  = shed_q;
    status[tds_pkg::ST_COOL]  = crun_q;
    timer = 32'h0;
    timer[11:0] = sec_q;
    timer[tds_pkg::TM_COOL +: 6] = cool_q;
  end

  // checks
  a_dwell_exit: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == tds_pkg::S_DWELLA && sec_q == 12'h000) |=> st_q == tds_pkg::S_ON_A)
    else $error("dwell toward alternate did not end at zero");
  a_dwell_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == tds_pkg::S_DWELLN && $past(st_q) != tds_pkg::S_DWELLN) |-> sec_q == dwell_s)
    else $error("dwell toward normal loaded a wrong time");
  a_retx_cancel: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == tds_pkg::S_RETX && !n_ok) |=> st_q == tds_pkg::S_ON_A)
    else $error("return not cancelled on normal failure");
  a_retx_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == tds_pkg::S_RETX && n_ok && !a_ok) |=> st_q == tds_pkg::S_DWELLN)
    else $error("return not immediate on alternate failure");
  a_gen_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(gen_start_o) |-> $past(st_q) == tds_pkg::S_GSTART && $past(sec_q) == 12'h000)
    else $error("generator started before its delay");
  a_no_return: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == tds_pkg::S_ON_A && !cfg_q.auto_ret) |=> st_q != tds_pkg::S_RETX)
    else $error("return timer ran without auto return");
  a_shed_out: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == tds_pkg::S_ON_A && cfg_q.shed_en)[*2] |-> load_shed_o)
    else $error("load shed not driven on alternate");
  a_cool_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(gen_stop_o) |-> $past(crun_q) && $past(cool_q) <= 6'h01)
    else $error("generator stopped before cool-down end");
  a_gdone_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (crun_q && !gdone_q && !a_ok) |=> cool_q == $past(cool_q))
    else $error("cool-down counted before start delay end");
endmodule // tds_core
`default_nettype wire

// ==== tb/tb_transfer_delay_sequencer.sv ====
// testbench of the transfer delay sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_transfer_delay_sequencer;
  // short tick keeps the minute-long delays affordable
  localparam int unsigned TK = 10;
  logic        clk_i, rst_i, cyc, stb, we, ack, n_up, a_up, gg, n_ok, a_ok;
  logic [3:0]  adr;
  logic [31:0] dw, dr, rs;
  logic [4:0]  o;
  logic [31:0] exp_q[$];
  int          n_mismatch, check_count;
  tds_core #(.TICK_CYC(TK)) tds_core_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dw), .dat_o(dr), .ack_o(ack),
    .n_ok_i(n_ok), .a_ok_i(a_ok), .pos_n_o(o[0]), .pos_a_o(o[1]), .gen_start_o(o[2]),
    .gen_stop_o(o[3]), .load_shed_o(o[4]));
  tds_src_model tds_src_model_inst (.clk_i(clk_i), .n_up_i(n_up), .a_up_i(a_up), .ug_i(gg),
    .gen_start_i(o[2]), .n_ok_o(n_ok), .a_ok_o(a_ok));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // read results are compared as they come back, oldest note first
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) chk("read data", exp_q.pop_front(), dr);
  end
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      chk("ack", 32'h1, {31'h0, ack});
      summarize();
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // waits for output k to reach v and checks the elapsed cycles lie in lo..hi
  task automatic wt(input int k, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (o[k] !== v && n <= hi) begin
      @(posedge clk_i);
      n++;
    end
    check_count++;
    if (n < lo || n > hi) begin
      n_mismatch++;
      $display("wrong value output %0d delay expected %0d..%0d seen %0d", k, lo, hi, n);
    end
    if (o[k] !== v) summarize();
  endtask
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, dw} = '0;
    {n_up, a_up, gg} = 3'b100;
    rs = 32'h19F50C2E;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("pos_n", 32'h1, {31'h0, o[0]});
    // alternate out of range first: the restart cool-down must not count yet
    repeat (100) @(posedge clk_i);
    a_up <= 1'b1;
    wt(3, 1'b1, 595, 625);
    rd(tds_pkg::ADR_STATUS, (32'h1 << tds_pkg::ST_N_OK) | (32'h1 << tds_pkg::ST_A_OK)
       | (32'h1 << tds_pkg::ST_POS_N) | (32'h1 << tds_pkg::ST_GSTOP));
    rd(tds_pkg::ADR_CTRL, 32'h0000310E);
    rs = lfsr(rs);
    wb(1'b1, 4'hC, rs);
    rd(4'hC, 32'h0);
    gg <= 1'b1;
    wb(1'b1, tds_pkg::ADR_CTRL, 32'h0000302E);
    n_up <= 1'b0;
    wt(2, 1'b1, 25, 50);
    wt(0, 1'b0, 10, 30);
    wt(1, 1'b1, 0, 3);
    wt(4, 1'b1, 0, 3);
    n_up <= 1'b1;
    wt(1, 1'b0, 0, 20);
    wt(0, 1'b1, 0, 3);
    wt(3, 1'b1, 595, 625);
    gg <= 1'b0;
    wb(1'b1, tds_pkg::ADR_CTRL, 32'h00000023);
    n_up <= 1'b0;
    wt(0, 1'b0, 1, 8);
    wt(1, 1'b1, 45, 70);
    n_up <= 1'b1;
    wt(1, 1'b0, 1, 20);
    wt(0, 1'b1, 45, 70);
    wb(1'b1, tds_pkg::ADR_CTRL, 32'h00000122);
    n_up <= 1'b0;
    wt(1, 1'b1, 1, 10);
    n_up <= 1'b1;
    repeat (100) @(posedge clk_i);
    n_up <= 1'b0;
    repeat (800) @(posedge clk_i);
    chk("pos_a", 32'h1, {31'h0, o[1]});
    n_up <= 1'b1;
    repeat (100) @(posedge clk_i);
    a_up <= 1'b0;
    wt(1, 1'b0, 1, 8);
    wt(0, 1'b1, 0, 3);
    a_up <= 1'b1;
    wb(1'b1, tds_pkg::ADR_CTRL, 32'h00000020);
    n_up <= 1'b0;
    wt(1, 1'b1, 1, 10);
    n_up <= 1'b1;
    repeat (200) @(posedge clk_i);
    chk("pos_a", 32'h1, {31'h0, o[1]});
    a_up <= 1'b0;
    wt(0, 1'b1, 1, 10);
    gg <= 1'b1;
    a_up <= 1'b1;
    wb(1'b1, tds_pkg::ADR_CTRL, 32'h00003004);
    n_up <= 1'b0;
    wt(2, 1'b1, 1, 8);
    summarize();
  end
endmodule // tb_transfer_delay_sequencer
`default_nettype wire

// ==== tb/tds_src_model.sv ====
// source sensor model: in-range flags of the normal source and the generator side
`timescale 1ns/10ps
`default_nettype none
module tds_src_model (
  // clock
  input  wire logic clk_i,
  // wanted source levels and generator coupling
  input  wire logic n_up_i,
  input  wire logic a_up_i,
  input  wire logic ug_i,
  input  wire logic gen_start_i,
  // sensor flags
  output logic      n_ok_o,
  output logic      a_ok_o
);
  logic [3:0] run_q;
  // a generator needs run-up time before its output is in range
  always_ff @(posedge clk_i) begin
    if (gen_start_i !== 1'b1) run_q <= 4'h0;
    else if (run_q != 4'hF) run_q <= run_q + 4'h1;
  end
  assign n_ok_o = n_up_i;
  assign a_ok_o = a_up_i & (!ug_i | (run_q == 4'hF));
endmodule // tds_src_model
`default_nettype wire
